// ==== verilog/dios_defs.vh ====
`ifndef DIOS_DEFS_VH
`define DIOS_DEFS_VH
`define DIOS_PREFIX_HI 4'h2
`define DIOS_PREFIX_LO 4'h0
`define DIOS_IDX_MIN 4'h1
`define DIOS_IDX_MAX 4'h2
`define DIOS_MR_MIN 10'h064
`define DIOS_MR_MAX 10'h3E7
`define DIOS_REG_INPUT_STATE 10'h064
`define DIOS_REG_OUTPUT_DRIVE 10'h065
`define DIOS_REG_OUTPUT_FAULT 10'h066
`define DIOS_REG_MODULE_CTRL 10'h067
`define DIOS_REG_FILTER_LOW 10'h068
`define DIOS_REG_FILTER_HIGH 10'h069
`define DIOS_FAULT_BIT 7
`define DIOS_FAULT_RESET 8'h80
`define DIOS_CTRL_RESET 8'h01
`define DIOS_POINT_MIN 7'h01
`define DIOS_POINT_MAX 7'h08
`endif

// ==== verilog/dios_regs.v ====
`timescale 1ns/100ps
`default_nettype none
`include "dios_defs.vh"
module dios_regs
(
    input wire ref_clk,
    input wire reset,
    input wire [3:0] my_riser_idx,
    input wire [3:0] my_submod_idx,
    input wire reg_wr,
    input wire reg_rd,
    input wire [3:0] reg_riser_idx,
    input wire [3:0] reg_submod_idx,
    input wire [9:0] reg_mr_num,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_hit,
    input wire io_rd,
    input wire io_wr,
    input wire io_wval,
    input wire [3:0] io_riser_idx,
    input wire [3:0] io_submod_idx,
    input wire [6:0] io_point_index,
    output reg io_rval,
    output reg io_hit,
    input wire [7:0] input_level,
    input wire supply_undervolt,
    input wire [7:0] output_short,
    input wire [7:0] output_overload,
    output wire [7:0] output_energize,
    output wire [7:0] module_ctrl,
    output wire [7:0] filter_low,
    output wire [7:0] filter_high
);
    // Register state
    reg [7:0] input_q;
    reg [7:0] drive_q;
    reg [7:0] drive_d;
    reg fault_q;
    reg fault_d;
    reg [7:0] ctrl_q;
    reg [7:0] flt_lo_q;
    reg [7:0] flt_hi_q;
    wire reg_sel;
    wire io_sel;
    wire [2:0] pt;
    wire fault_now;
    wire [7:0] fault_rst;
    wire reg_acc;
    wire io_acc;
    wire rd_take;
    wire wr_take;
    wire wr_ctrl;
    wire wr_flt_lo;
    wire wr_flt_hi;
    wire pt_rd;
    wire [7:0] rd_word;

    // Riser and submodule match
    function sel_ok;
        input [3:0] riser;
        input [3:0] submod;
        input [3:0] mine_r;
        input [3:0] mine_s;
        begin
            sel_ok = (riser >= `DIOS_IDX_MIN) && (riser <= `DIOS_IDX_MAX) &&
                (submod >= `DIOS_IDX_MIN) && (submod <= `DIOS_IDX_MAX) &&
                (riser == mine_r) && (submod == mine_s);
        end
    endfunction

    // Exact module register match
    function mr_is;
        input [9:0] mr;
        input [9:0] code;
        begin
            mr_is = (mr == code);
        end
    endfunction

    // Read data of one register, zero where unimplemented
    function [7:0] rd_mux;
        input [9:0] mr;
        input [7:0] in_v;
        input [7:0] drv_v;
        input flag_v;
        input [7:0] ctrl_v;
        input [7:0] lo_v;
        input [7:0] hi_v;
        begin
            case (mr)
                `DIOS_REG_INPUT_STATE: rd_mux = in_v;
                `DIOS_REG_OUTPUT_DRIVE: rd_mux = drv_v;
                `DIOS_REG_OUTPUT_FAULT: rd_mux = {flag_v, 7'h00};
                `DIOS_REG_MODULE_CTRL: rd_mux = ctrl_v;
                `DIOS_REG_FILTER_LOW: rd_mux = lo_v;
                `DIOS_REG_FILTER_HIGH: rd_mux = hi_v;
                default: rd_mux = 8'h00;
            endcase
        end
    endfunction

    assign reg_sel = sel_ok(reg_riser_idx, reg_submod_idx, my_riser_idx, my_submod_idx)
        && (reg_mr_num >= `DIOS_MR_MIN) && (reg_mr_num <= `DIOS_MR_MAX);
    assign io_sel = sel_ok(io_riser_idx, io_submod_idx, my_riser_idx, my_submod_idx)
        && (io_point_index >= `DIOS_POINT_MIN) && (io_point_index <= `DIOS_POINT_MAX);
    assign pt = io_point_index[2:0] - 3'h1;
    assign fault_now = supply_undervolt | (|output_short) | (|output_overload);

    // Access strobes
    assign fault_rst = `DIOS_FAULT_RESET;
    assign reg_acc = (reg_rd | reg_wr) & reg_sel;
    assign io_acc = (io_rd | io_wr) & io_sel;
    assign rd_take = reg_rd & reg_sel;
    assign wr_take = reg_wr & reg_sel;
    assign wr_ctrl = wr_take & mr_is(reg_mr_num, `DIOS_REG_MODULE_CTRL);
    assign wr_flt_lo = wr_take & mr_is(reg_mr_num, `DIOS_REG_FILTER_LOW);
    assign wr_flt_hi = wr_take & mr_is(reg_mr_num, `DIOS_REG_FILTER_HIGH);
    assign pt_rd = drive_q[pt];
    assign rd_word = rd_mux(reg_mr_num, input_q, drive_q, fault_q,
        ctrl_q, flt_lo_q, flt_hi_q);

    assign output_energize = drive_q;
    assign module_ctrl = ctrl_q;
    assign filter_low = flt_lo_q;
    assign filter_high = flt_hi_q;

    always @*
    begin
        drive_d = drive_q;
        if (reg_wr && reg_sel && reg_mr_num == `DIOS_REG_OUTPUT_DRIVE)
        begin
            drive_d = reg_wdata;
        end
        if (io_wr && io_sel)
        begin
            drive_d[pt] = io_wval;
        end
    end

    always @*
    begin
        fault_d = fault_q;
        if (reg_wr && reg_sel && reg_mr_num == `DIOS_REG_OUTPUT_FAULT)
        begin
            fault_d = 1'b0;
        end
        if (fault_now)
        begin
            fault_d = 1'b1;
        end
    end

    // Input sample
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            input_q <= 8'h00;
        end
        else
        begin
            input_q <= input_level;
        end
    end

    // Output drive
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            drive_q <= 8'h00;
        end
        else
        begin
            drive_q <= drive_d;
        end
    end

    // Collective fault flag, set after reset
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            fault_q <= fault_rst[`DIOS_FAULT_BIT];
        end
        else
        begin
            fault_q <= fault_d;
        end
    end

    // Control register, no logic behind it
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            ctrl_q <= `DIOS_CTRL_RESET;
        end
        else if (wr_ctrl)
        begin
            ctrl_q <= reg_wdata;
        end
    end

    // Low filter register
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            flt_lo_q <= 8'h00;
        end
        else if (wr_flt_lo)
        begin
            flt_lo_q <= reg_wdata;
        end
    end

    // High filter register
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            flt_hi_q <= 8'h00;
        end
        else if (wr_flt_hi)
        begin
            flt_hi_q <= reg_wdata;
        end
    end

    // Register hit, registered at the taking edge
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            reg_hit <= 1'b0;
        end
        else
        begin
            reg_hit <= reg_acc;
        end
    end

    // Read data, zero unless a read was taken
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            reg_rdata <= 8'h00;
        end
        else if (rd_take)
        begin
            reg_rdata <= rd_word;
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end

    // Point hit
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            io_hit <= 1'b0;
        end
        else
        begin
            io_hit <= io_acc;
        end
    end

    // Point readback
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            io_rval <= 1'b0;
        end
        else if (io_rd && io_sel)
        begin
            io_rval <= pt_rd;
        end
        else
        begin
            io_rval <= 1'b0;
        end
    end
endmodule // dios_regs
`default_nettype wire

// ==== dv/dios_regs_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module dios_regs_asserts (
    input wire logic ref_clk, reset, reg_wr, reg_rd, reg_hit, supply_undervolt,
    input wire logic [3:0] my_riser_idx, my_submod_idx, reg_riser_idx, reg_submod_idx,
    input wire logic [9:0] reg_mr_num,
    input wire logic [7:0] reg_rdata, output_short, output_overload
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    wire dec = reg_riser_idx == my_riser_idx && reg_submod_idx == my_submod_idx
        && reg_mr_num inside {[10'h064:10'h3E7]};
    wire acc = (reg_rd || reg_wr) && dec;
    wire flt = supply_undervolt || |output_short || |output_overload;
    wire rdf = reg_rd && dec && reg_mr_num == 10'h066;
    sequence clr_s;
        reg_wr && dec && reg_mr_num == 10'h066 && !flt ##1 !flt;
    endsequence
    sequence held_s;
        (rdf && !reg_wr) ##1 reg_rdata[7] && !reg_wr;
    endsequence
    reset_vals_a: assert property (disable iff (1'h0) reset |=> !reg_hit && !reg_rdata)
        else $error("reset");
    hit_taken_a: assert property (acc |=> reg_hit) else $error("hit");
    hit_refused_a: assert property (!acc |=> !reg_hit) else $error("stray");
    rdata_idle_a: assert property (!(reg_rd && dec) |=> !reg_rdata) else $error("idle");
    flag_bits_a: assert property (rdf |=> !reg_rdata[6:0]) else $error("bits");
    flag_set_a: assert property (flt ##1 rdf |=> reg_rdata[7]) else $error("set");
    flag_held_a: assert property (held_s ##1 rdf |=> reg_rdata[7]) else $error("held");
    flag_clear_a: assert property (clr_s ##1 rdf |=> !reg_rdata[7]) else $error("clr");
endmodule // dios_regs_asserts
bind dios_regs dios_regs_asserts chk (.*);
`default_nettype wire

// ==== dv/dios_cpu_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module dios_cpu_model (
    input wire logic ref_clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [9:0] reg_mr_num,
    output logic [7:0] reg_wdata
);
    initial {reg_wr, reg_rd, reg_mr_num, reg_wdata} = 20'h0_0000;
    task automatic acc(input logic w, input logic [9:0] mr, input logic [7:0] d);
        @(posedge ref_clk) #1;
        {reg_wr, reg_rd, reg_mr_num, reg_wdata} = {w, !w, mr, d};
        @(posedge ref_clk) #1;
        {reg_wr, reg_rd, reg_wdata} = {2'h0, ~d};
    endtask
endmodule // dios_cpu_model
`default_nettype wire

// ==== dv/dios_regs_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module dios_regs_tb_top;
    logic ref_clk = 1'h0, reset = 1'h1, supply_undervolt = 1'h0, io_wr = 1'h0, reg_wr, reg_rd;
    logic io_rd = 1'h0, io_wval = 1'h0, io_rval, io_hit;
    logic [7:0] module_ctrl, filter_low, filter_high;
    int m_drive = 0;
    logic [3:0] reg_riser_idx = 4'h1, reg_submod_idx = 4'h2;
    logic [6:0] io_point_index = 7'h03;
    logic [9:0] reg_mr_num;
    logic [7:0] reg_wdata, reg_rdata, output_energize, xd, input_level = 8'h00;
    logic [7:0] output_short = 8'h00, output_overload = 8'h00;
    int fail_count = 0, n_tests = 0;
    int unsigned sd = 67;
    dios_cpu_model cpu (.*);
    dios_regs uut (.*, .my_riser_idx(4'h1), .my_submod_idx(4'h2),
        .io_riser_idx(reg_riser_idx), .io_submod_idx(reg_submod_idx), .reg_hit());
    function automatic logic [7:0] rnd();
        sd ^= sd << 13;
        sd ^= sd >> 17;
        sd ^= sd << 5;
        return sd[7:0];
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        cpu.acc(1'h0, a, 8'h00);
        chk(reg_rdata, e);
    endtask
    task automatic summarize();
        if (fail_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial forever #5 ref_clk = ~ref_clk;
    initial
    begin
        #20000;
        fail_count++;
        summarize();
    end
    initial
    begin
        repeat (4) @(posedge ref_clk);
        #1 reset = 1'h0;
        rd(10'h066, 8'h80);
        rd(10'h066, 8'h80);
        chk(module_ctrl, 8'h01);
        cpu.acc(1'h1, 10'h067, 8'h5A);
        cpu.acc(1'h1, 10'h068, 8'hC3);
        cpu.acc(1'h1, 10'h069, 8'h3C);
        chk(module_ctrl, 8'h5A);
        chk(filter_low, 8'hC3);
        chk(filter_high, 8'h3C);
        rd(10'h069, 8'h3C);
        rd(10'h06A, 8'h00);
        repeat (8)
        begin
            xd = rnd();
            m_drive = xd;
            input_level = rnd();
            cpu.acc(1'h1, 10'h065, xd);
            chk(output_energize, m_drive[7:0]);
            rd(10'h065, xd);
            rd(10'h064, input_level);
        end
        reg_riser_idx = 4'h3;
        cpu.acc(1'h1, 10'h065, ~xd);
        reg_riser_idx = 4'h1;
        cpu.acc(1'h1, 10'h3E8, ~xd);
        chk(output_energize, m_drive[7:0]);
        io_wval = ~xd[2];
        m_drive[2] = io_wval;
        io_wr = 1'h1;
        @(posedge ref_clk) #1 {io_wr, io_rd} = 2'h1;
        chk(output_energize, m_drive[7:0]);
        @(posedge ref_clk) #1 io_point_index = 7'h09;
        chk({6'h00, io_hit, io_rval}, {6'h00, 1'h1, m_drive[2]});
        @(posedge ref_clk) #1 io_rd = 1'h0;
        chk({7'h00, io_hit}, 8'h00);
        io_point_index = 7'h03;
        for (int k = 0; k < 3; k++)
        begin
            {supply_undervolt, output_short[0], output_overload[7]} = 3'h4 >> k;
            rd(10'h066, 8'h80);
            {supply_undervolt, output_short[0], output_overload[7]} = 3'h0;
            rd(10'h066, 8'h80);
            cpu.acc(1'h1, 10'h066, rnd());
            rd(10'h066, 8'h00);
        end
        output_short[3] = 1'h1;
        cpu.acc(1'h1, 10'h066, rnd());
        output_short[3] = 1'h0;
        rd(10'h066, 8'h80);
        summarize();
    end
endmodule // dios_regs_tb_top
`default_nettype wire
